// [rtl/crag_pkg.sv]
// constants, codes and types of the cpu register and address generator
package crag_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // ----------------------------------------
  // operand address modes
  // ----------------------------------------
  localparam logic [3:0] MODE_DIRECT = 4'h0;
  localparam logic [3:0] MODE_EXTENDED = 4'h1;
  localparam logic [3:0] MODE_IMMEDIATE = 4'h2;
  localparam logic [3:0] MODE_INDEXED_NO_OFFSET = 4'h3;
  localparam logic [3:0] MODE_INDEXED_POST_INCREMENT = 4'h4;
  localparam logic [3:0] MODE_INDEXED_BYTE_OFFSET = 4'h5;
  localparam logic [3:0] MODE_INDEXED_BYTE_OFFSET_POST_INCREMENT = 4'h6;
  localparam logic [3:0] MODE_INDEXED_WORD_OFFSET = 4'h7;
  localparam logic [3:0] MODE_STACK_BYTE_OFFSET = 4'h8;
  localparam logic [3:0] MODE_STACK_WORD_OFFSET = 4'h9;
  localparam logic [3:0] MODE_RELATIVE = 4'hA;
  // ----------------------------------------
  // operations on the index low byte
  // ----------------------------------------
  localparam logic [3:0] XOP_CLEAR = 4'h0;
  localparam logic [3:0] XOP_INCREMENT = 4'h1;
  localparam logic [3:0] XOP_DECREMENT = 4'h2;
  localparam logic [3:0] XOP_COMPLEMENT = 4'h3;
  localparam logic [3:0] XOP_NEGATE = 4'h4;
  localparam logic [3:0] XOP_SHIFT_LEFT = 4'h5;
  localparam logic [3:0] XOP_SHIFT_RIGHT = 4'h6;
  localparam logic [3:0] XOP_SHIFT_RIGHT_ARITH = 4'h7;
  localparam logic [3:0] XOP_ROTATE_LEFT = 4'h8;
  localparam logic [3:0] XOP_ROTATE_RIGHT = 4'h9;
  // ----------------------------------------
  // fixed values
  // ----------------------------------------
  localparam logic [7:0] IDX_H_RESET = 8'h00;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [15:0] POST_INC_STEP = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } crag_state_type;
endpackage

// [rtl/crag_core.sv]
// cpu accumulator, index pair and effective address generator
// Operation
// - accumulator is an 8-bit register loaded with alu results
// - reset leaves the accumulator untouched
// - index pair is two 8-bit registers, high and low address bytes
// - all indexed modes use the full 16-bit pair as base
// - reset loads the index high byte with zero
// - reset leaves the index low byte untouched
// - low index byte supports clear, inc, dec, complement, negate, shift, rotate
// - indexed no offset address equals the pair
// - post increment mode fetches at pair, then pair plus one
// - byte offset address is pair plus zero-extended offset
// - byte offset post increment fetches at pair plus offset, then pair plus one
// - word offset address is pair plus 16-bit offset
// - stack byte offset address is stack pointer plus unsigned byte
// - stack word offset address is stack pointer plus 16-bit offset
// - direct address has zero high byte and operand low byte
// - 16-bit offset comes from an upper and a lower byte
// - 16-bit immediate is built from high and low bytes
// - extended address is built from high and low bytes
// - branch target is next address plus signed byte offset
// - address bus is 16 bits; word offset may be signed or unsigned
`timescale 1ns/100ps
module crag_core (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // address request
  input wire logic EA_REQ,
  input wire logic [3:0] EA_MODE,
  input wire logic [7:0] OPND_HI,
  input wire logic [7:0] OPND_LO,
  input wire logic [15:0] STACK_PTR,
  input wire logic [15:0] NEXT_PC,
  input wire logic READ_DONE,
  // accumulator load
  input wire logic ACC_LOAD,
  input wire logic [7:0] ACC_DATA,
  // index loads and low byte operations
  input wire logic IDX_H_LOAD,
  input wire logic [7:0] IDX_H_DATA,
  input wire logic IDX_L_LOAD,
  input wire logic [7:0] IDX_L_DATA,
  input wire logic IDX_L_OP,
  input wire logic [3:0] IDX_L_OP_CODE,
  input wire logic CARRY_IN,
  // address result
  output logic [15:0] EA,
  output logic EA_VALID,
  output logic BUSY,
  // register contents
  output logic [7:0] ACC,
  output logic [7:0] IDX_H,
  output logic [7:0] IDX_L,
  output logic IDX_CARRY
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic mode_legal(input logic [3:0] m);
    mode_legal = (m <= crag_pkg::MODE_RELATIVE);
  endfunction

  function automatic logic mode_post(input logic [3:0] m);
    mode_post = (m == crag_pkg::MODE_INDEXED_POST_INCREMENT) ||
                (m == crag_pkg::MODE_INDEXED_BYTE_OFFSET_POST_INCREMENT);
  endfunction

  // sums are 16 bits wide on purpose so wrap-around is free
  function automatic logic [15:0] ea_calc(input logic [3:0] m, input logic [15:0] base,
                                          input logic [15:0] sp, input logic [15:0] pc,
                                          input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] word;
    logic [15:0] zext;
    logic [15:0] sext;
    word = {hi, lo};
    zext = {crag_pkg::BYTE_ZERO, lo};
    sext = {{(crag_pkg::ADDR_W - crag_pkg::DATA_W){lo[7]}}, lo};
    case (m)
      crag_pkg::MODE_DIRECT: ea_calc = {crag_pkg::DIRECT_PAGE, lo};
      crag_pkg::MODE_EXTENDED: ea_calc = word;
      crag_pkg::MODE_IMMEDIATE: ea_calc = word;
      crag_pkg::MODE_INDEXED_NO_OFFSET: ea_calc = base;
      crag_pkg::MODE_INDEXED_POST_INCREMENT: ea_calc = base;
      crag_pkg::MODE_INDEXED_BYTE_OFFSET: ea_calc = base + zext;
      crag_pkg::MODE_INDEXED_BYTE_OFFSET_POST_INCREMENT: ea_calc = base + zext;
      crag_pkg::MODE_INDEXED_WORD_OFFSET: ea_calc = base + word;
      crag_pkg::MODE_STACK_BYTE_OFFSET: ea_calc = sp + zext;
      crag_pkg::MODE_STACK_WORD_OFFSET: ea_calc = sp + word;
      crag_pkg::MODE_RELATIVE: ea_calc = pc + sext;
      default: ea_calc = word;
    endcase
  endfunction

  // carry is the top bit of the result
  function automatic logic [8:0] xop_calc(input logic [3:0] op, input logic [7:0] x,
                                          input logic cin, input logic cold);
    case (op)
      crag_pkg::XOP_CLEAR: xop_calc = {cold, crag_pkg::BYTE_ZERO};
      crag_pkg::XOP_INCREMENT: xop_calc = {cold, x + crag_pkg::BYTE_ONE};
      crag_pkg::XOP_DECREMENT: xop_calc = {cold, x - crag_pkg::BYTE_ONE};
      crag_pkg::XOP_COMPLEMENT: xop_calc = {cold, ~x};
      crag_pkg::XOP_NEGATE: xop_calc = {x != crag_pkg::BYTE_ZERO, crag_pkg::BYTE_ZERO - x};
      crag_pkg::XOP_SHIFT_LEFT: xop_calc = {x[7], x[6:0], 1'b0};
      crag_pkg::XOP_SHIFT_RIGHT: xop_calc = {x[0], 1'b0, x[7:1]};
      crag_pkg::XOP_SHIFT_RIGHT_ARITH: xop_calc = {x[0], x[7], x[7:1]};
      crag_pkg::XOP_ROTATE_LEFT: xop_calc = {x[7], x[6:0], cin};
      crag_pkg::XOP_ROTATE_RIGHT: xop_calc = {x[0], cin, x[7:1]};
      default: xop_calc = {cold, x};
    endcase
  endfunction

  // ----------------------------------------
  // state and datapath signals
  // ----------------------------------------
  crag_pkg::crag_state_type state;
  crag_pkg::crag_state_type next_state;
  logic [7:0] acc;
  logic [7:0] idx_h;
  logic [7:0] idx_l;
  logic carry;
  logic [15:0] ea;
  logic ea_valid;
  logic busy;
  logic [15:0] pair;
  logic [15:0] pair_inc;
  logic accept;
  logic bump;
  logic idle;
  logic [8:0] xop_res;

  assign pair = {idx_h, idx_l};
  assign pair_inc = pair + crag_pkg::POST_INC_STEP;
  assign idle = (state == crag_pkg::ST_IDLE);
  // illegal modes and requests during a pending increment are dropped
  assign accept = EA_REQ && idle && mode_legal(EA_MODE);
  // no increment under reset, so the low byte really is left alone
  assign bump = (state == crag_pkg::ST_WAIT) && READ_DONE && !SRST;
  assign xop_res = xop_calc(IDX_L_OP_CODE, idx_l, CARRY_IN, carry);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      crag_pkg::ST_IDLE: begin
        if (accept && mode_post(EA_MODE)) begin
          next_state = crag_pkg::ST_WAIT;
        end
      end
      crag_pkg::ST_WAIT: begin
        if (READ_DONE) begin
          next_state = crag_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state <= crag_pkg::ST_IDLE;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      busy <= (next_state == crag_pkg::ST_WAIT);
    end
  end

  // ----------------------------------------
  // address result
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ea <= 16'h0000;
      ea_valid <= 1'b0;
    end else begin
      ea_valid <= accept;
      if (accept) begin
        ea <= ea_calc(EA_MODE, pair, STACK_PTR, NEXT_PC, OPND_HI, OPND_LO);
      end
    end
  end

  // ----------------------------------------
  // accumulator, never reset
  // ----------------------------------------
  always_ff @(posedge MCLK) begin
    if (ACC_LOAD) begin
      acc <= ACC_DATA;
    end
  end

  // ----------------------------------------
  // index pair
  // ----------------------------------------
  // loads are ignored while an increment is pending so the pointer cannot be torn
  always_ff @(posedge MCLK) begin
    if (bump) begin
      idx_l <= pair_inc[7:0];
    end else if (idle && IDX_L_LOAD) begin
      idx_l <= IDX_L_DATA;
    end else if (idle && IDX_L_OP) begin
      idx_l <= xop_res[7:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      idx_h <= crag_pkg::IDX_H_RESET;
    end else if (bump) begin
      idx_h <= pair_inc[15:8];
    end else if (idle && IDX_H_LOAD) begin
      idx_h <= IDX_H_DATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      carry <= 1'b0;
    end else if (idle && !IDX_L_LOAD && IDX_L_OP && !bump) begin
      carry <= xop_res[8];
    end
  end

  assign EA = ea;
  assign EA_VALID = ea_valid;
  assign BUSY = busy;
  assign ACC = acc;
  assign IDX_H = idx_h;
  assign IDX_L = idx_l;
  assign IDX_CARRY = carry;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_acc_load;
    @(posedge MCLK) ACC_LOAD |=> (ACC == $past(ACC_DATA));
  endproperty
  a_acc_load: assert property (p_acc_load) else $error("accumulator load lost");

  property p_acc_reset;
    @(posedge MCLK) (SRST && !ACC_LOAD) |=> $stable(ACC);
  endproperty
  a_acc_reset: assert property (p_acc_reset) else $error("reset changed accumulator");

  property p_h_reset;
    @(posedge MCLK) SRST |=> (IDX_H == crag_pkg::IDX_H_RESET);
  endproperty
  a_h_reset: assert property (p_h_reset) else $error("index high not cleared by reset");

  property p_l_reset;
    @(posedge MCLK) (SRST && !IDX_L_LOAD && !IDX_L_OP) |=> $stable(IDX_L);
  endproperty
  a_l_reset: assert property (p_l_reset) else $error("reset changed index low");

  property p_xop_inc;
    @(posedge MCLK) disable iff (SRST)
      (idle && IDX_L_OP && !IDX_L_LOAD && !IDX_H_LOAD && IDX_L_OP_CODE == crag_pkg::XOP_INCREMENT)
      |=> (IDX_L == 8'($past(idx_l) + crag_pkg::BYTE_ONE)) && $stable(IDX_H);
  endproperty
  a_xop_inc: assert property (p_xop_inc) else $error("low byte increment wrong");

  property p_ea_ix;
    @(posedge MCLK) disable iff (SRST)
      (accept && EA_MODE == crag_pkg::MODE_INDEXED_NO_OFFSET) |=> (EA_VALID && EA == $past(pair));
  endproperty
  a_ea_ix: assert property (p_ea_ix) else $error("no offset address wrong");

  property p_ea_ix1;
    @(posedge MCLK) disable iff (SRST)
      (accept && EA_MODE == crag_pkg::MODE_INDEXED_BYTE_OFFSET)
      |=> (EA == 16'($past(pair) + {8'h00, $past(OPND_LO)}));
  endproperty
  a_ea_ix1: assert property (p_ea_ix1) else $error("byte offset address wrong");

  property p_ea_ix2;
    @(posedge MCLK) disable iff (SRST)
      (accept && EA_MODE == crag_pkg::MODE_INDEXED_WORD_OFFSET)
      |=> (EA == 16'($past(pair) + {$past(OPND_HI), $past(OPND_LO)}));
  endproperty
  a_ea_ix2: assert property (p_ea_ix2) else $error("word offset address wrong");

  property p_ea_sp1;
    @(posedge MCLK) disable iff (SRST)
      (accept && EA_MODE == crag_pkg::MODE_STACK_BYTE_OFFSET)
      |=> (EA == 16'($past(STACK_PTR) + {8'h00, $past(OPND_LO)}));
  endproperty
  a_ea_sp1: assert property (p_ea_sp1) else $error("stack byte address wrong");

  property p_ea_dir;
    @(posedge MCLK) disable iff (SRST)
      (accept && EA_MODE == crag_pkg::MODE_DIRECT) |=> (EA == {8'h00, $past(OPND_LO)});
  endproperty
  a_ea_dir: assert property (p_ea_dir) else $error("direct address wrong");

  property p_ea_rel;
    @(posedge MCLK) disable iff (SRST)
      (accept && EA_MODE == crag_pkg::MODE_RELATIVE)
      |=> (EA == 16'($past(NEXT_PC) + {{8{$past(OPND_LO[7])}}, $past(OPND_LO)}));
  endproperty
  a_ea_rel: assert property (p_ea_rel) else $error("branch target wrong");

  property p_post_hold;
    @(posedge MCLK) disable iff (SRST)
      (state == crag_pkg::ST_WAIT && !READ_DONE) |=> ($stable(pair) && BUSY);
  endproperty
  a_post_hold: assert property (p_post_hold) else $error("pair moved before read done");

  property p_post_inc;
    @(posedge MCLK) disable iff (SRST)
      bump |=> (pair == 16'($past(pair) + crag_pkg::POST_INC_STEP)) && !BUSY;
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment wrong");

endmodule

// [verif/crag_mem_model.sv]
// memory bus partner that completes operand reads after a set delay
`timescale 1ns/100ps
module crag_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // bus view
  input wire logic busy,
  input wire logic [3:0] delay,
  output logic read_done
);
  logic [3:0] cnt;
  // ----------------------------------------
  // read completion
  // ----------------------------------------
  // a slow memory stretches the pending increment; done is a one-cycle pulse
  always_ff @(posedge mclk) begin
    if (srst || !busy) begin
      cnt <= 4'h0;
      read_done <= 1'b0;
    end else if (read_done) begin
      read_done <= 1'b0;
    end else if (cnt == delay) begin
      read_done <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// [verif/testbench.sv]
// self-checking bench for the register set and address generator
`timescale 1ns/100ps
module testbench;
  logic mclk, srst, ea_req, read_done, acc_load, idx_h_load, idx_l_load, idx_l_op, carry_in;
  logic [3:0] ea_mode, idx_l_op_code, delay;
  logic [7:0] opnd_hi, opnd_lo, acc_data, idx_h_data, idx_l_data, acc, idx_h, idx_l;
  logic [15:0] stack_ptr, next_pc, ea;
  logic ea_valid, busy, idx_carry;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  logic [3:0] mlist [0:8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA};
  logic [7:0] opexp [0:9] = '{8'h00, 8'h82, 8'h80, 8'h7E, 8'h7F, 8'h02, 8'h40, 8'hC0, 8'h03, 8'hC0};

  crag_core dut (.MCLK(mclk), .SRST(srst), .EA_REQ(ea_req), .EA_MODE(ea_mode), .OPND_HI(opnd_hi),
    .OPND_LO(opnd_lo), .STACK_PTR(stack_ptr), .NEXT_PC(next_pc), .READ_DONE(read_done),
    .ACC_LOAD(acc_load), .ACC_DATA(acc_data), .IDX_H_LOAD(idx_h_load), .IDX_H_DATA(idx_h_data),
    .IDX_L_LOAD(idx_l_load), .IDX_L_DATA(idx_l_data), .IDX_L_OP(idx_l_op), .IDX_L_OP_CODE(idx_l_op_code),
    .CARRY_IN(carry_in), .EA(ea), .EA_VALID(ea_valid), .BUSY(busy), .ACC(acc), .IDX_H(idx_h),
    .IDX_L(idx_l), .IDX_CARRY(idx_carry));
  crag_mem_model mem (.mclk(mclk), .srst(srst), .busy(busy), .delay(delay), .read_done(read_done));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  task automatic report_and_stop;
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // expected address worked out from the mode, the operand bytes and the pair
  function automatic logic [15:0] exp_ea(input logic [3:0] m, input logic [7:0] h, input logic [7:0] l,
                                         input logic [15:0] x);
    case (m)
      crag_pkg::MODE_DIRECT: exp_ea = {8'h00, l};
      crag_pkg::MODE_EXTENDED, crag_pkg::MODE_IMMEDIATE: exp_ea = {h, l};
      crag_pkg::MODE_INDEXED_NO_OFFSET, crag_pkg::MODE_INDEXED_POST_INCREMENT: exp_ea = x;
      crag_pkg::MODE_INDEXED_BYTE_OFFSET, crag_pkg::MODE_INDEXED_BYTE_OFFSET_POST_INCREMENT: exp_ea = x + {8'h00, l};
      crag_pkg::MODE_INDEXED_WORD_OFFSET: exp_ea = x + {h, l};
      crag_pkg::MODE_STACK_BYTE_OFFSET: exp_ea = stack_ptr + {8'h00, l};
      crag_pkg::MODE_STACK_WORD_OFFSET: exp_ea = stack_ptr + {h, l};
      default: exp_ea = next_pc + {{8{l[7]}}, l};
    endcase
  endfunction
  task automatic load_pair(input logic [15:0] x);
    idx_h_load = 1'b1;
    idx_l_load = 1'b1;
    {idx_h_data, idx_l_data} = x;
    step();
    idx_h_load = 1'b0;
    idx_l_load = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    acc_load = 1'b1;
    acc_data = 8'h3C;
    load_pair(16'h77A5);
    acc_load = 1'b0;
    check("acc load", acc, 8'h3C);
    srst = 1'b1;
    step();
    step();
    srst = 1'b0;
    check("acc kept", acc, 8'h3C);
    check("idx_h reset", idx_h, 8'h00);
    check("idx_l kept", idx_l, 8'hA5);
  endtask
  // every non-post mode back to back, wrap-around sums included
  task automatic t_modes;
    load_pair(16'hFF80);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 9; i++) begin
        ea_req = 1'b1;
        ea_mode = mlist[i];
        {opnd_hi, opnd_lo} = (j == 0) ? 16'h12F0 : 16'h8005;
        step();
        check("ea_valid", ea_valid, 1'b1);
        check("ea", ea, exp_ea(mlist[i], opnd_hi, opnd_lo, 16'hFF80));
      end
    end
    ea_mode = 4'hB;
    step();
    ea_req = 1'b0;
    check("ea_valid illegal", ea_valid, 1'b0);
    step();
    check("ea_valid drop", ea_valid, 1'b0);
  endtask
  task automatic t_post(input logic [3:0] m, input logic [15:0] x, input logic [7:0] l, input logic [3:0] d);
    delay = d;
    load_pair(x);
    ea_req = 1'b1;
    ea_mode = m;
    opnd_lo = l;
    step();
    check("post ea", ea, exp_ea(m, 8'h00, l, x));
    check("post valid", ea_valid, 1'b1);
    check("post busy", busy, 1'b1);
    ea_mode = crag_pkg::MODE_DIRECT;
    idx_l_load = 1'b1;
    idx_l_data = 8'h55;
    step();
    ea_req = 1'b0;
    idx_l_load = 1'b0;
    check("busy refused", ea_valid, 1'b0);
    for (int k = 0; k < 20 && busy !== 1'b0; k++) begin
      check("pair held", {idx_h, idx_l}, x);
      step();
    end
    check("pair inc", {idx_h, idx_l}, x + 16'h0001);
    check("ea holds", ea, exp_ea(m, 8'h00, l, x));
  endtask
  // low byte ops with a marker in the high byte that must survive
  task automatic t_ops;
    carry_in = 1'b1;
    for (int i = 0; i < 10; i++) begin
      load_pair(16'h5A81);
      idx_l_op = 1'b1;
      idx_l_op_code = 4'(i);
      step();
      idx_l_op = 1'b0;
      check("idx_l op", idx_l, opexp[i]);
      check("idx_h untouched", idx_h, 8'h5A);
      check("carry", idx_carry, (i >= 4) ? 1'b1 : 1'b0);
    end
    load_pair(16'h5A41);
    idx_l_op = 1'b1;
    idx_l_op_code = crag_pkg::XOP_SHIFT_LEFT;
    step();
    idx_l_op = 1'b0;
    check("idx_l shift", idx_l, 8'h82);
    check("carry clear", idx_carry, 1'b0);
  endtask
  // ----------------------------------------
  // main sequence and timeout
  // ----------------------------------------
  initial begin
    {srst, ea_req, acc_load, idx_h_load, idx_l_load, idx_l_op, carry_in} = 7'h40;
    {ea_mode, idx_l_op_code, delay} = 12'h000;
    {opnd_hi, opnd_lo, acc_data, idx_h_data, idx_l_data} = 40'h0;
    stack_ptr = 16'hFFF0;
    next_pc = 16'h1000;
    repeat (4) @(posedge mclk);
    #1;
    srst = 1'b0;
    t_reset();
    t_modes();
    t_post(crag_pkg::MODE_INDEXED_POST_INCREMENT, 16'hFFFF, 8'h00, 4'h3);
    t_post(crag_pkg::MODE_INDEXED_BYTE_OFFSET_POST_INCREMENT, 16'h12FF, 8'h01, 4'h0);
    t_ops();
    report_and_stop();
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      report_and_stop();
    end
  end
endmodule
